// ---- srwa_pkg.sv ----
// Purpose: shared constants for the sysref window and alignment calibration block
// Assumes: AXI4-Lite register access, 32-bit data, one register per aligned word
// Notes:   register indices are multiplied by four to form byte addresses
package srwa_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices and address width
  localparam logic [11:0] CLK_CTRL0_IDX  = 12'h029;
  localparam logic [11:0] POS_FLAGS0_IDX = 12'h02C;
  localparam logic [11:0] POS_FLAGS1_IDX = 12'h02D;
  localparam logic [11:0] POS_FLAGS2_IDX = 12'h02E;
  localparam logic [11:0] CAL_EN_IDX     = 12'h2B0;
  localparam logic [11:0] CAL_CFG_IDX    = 12'h2B1;
  localparam logic [11:0] CAL_STAT_IDX   = 12'h2B2;
  localparam logic [11:0] TAD_IDX        = 12'h2B8;
  localparam int          ADDR_W         = 12;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int SEL_LSB     = 0;
  localparam int SEL_W       = 4;
  localparam int STEP_BIT    = 4;
  localparam int CLOCK_INVERT_DELAY_BIT = 16;
  localparam int TAD_CRS_LSB = 8;
  localparam int TAD_FIN_LSB = 0;
  localparam int STAT_DONE   = 24;
  localparam int STAT_VALID  = 25;
  localparam int STAT_NOLOCK = 26;
  localparam int NUM_POS     = 24;
  localparam int DLY_W       = 8;

  ////////////////////////////////////////////////////////////////////////////
  // reset values and limits
  localparam logic [31:0] CLK_CTRL0_RST = 32'h0000_0000;
  localparam logic [31:0] CAL_CFG_RST   = 32'h0000_0000;
  localparam logic [31:0] TAD_RST       = 32'h0000_0000;
  localparam logic [7:0]  COARSE_MAX    = 8'hFF;
  localparam logic [1:0]  EDGES_NEEDED  = 2'h3;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SETTLE_NS     = 2000;
  localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    CAL_IDLE,
    CAL_SETTLE,
    CAL_WAIT_EDGE,
    CAL_CHECK,
    CAL_FINISH
  } srwa_cal_state_type;

endpackage : srwa_pkg

// ---- srwa_sysref_window_autocal.sv ----
// Purpose: sysref position detector, sampling position select and automatic
//          aperture delay search, behind an AXI4-Lite register slave
// Assumes: analog taps and phase comparator are asynchronous to i_sys_clk
// Notes:   one clock domain, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module srwa_sysref_window_autocal
  import srwa_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC
) (
  // clock and reset
  input  wire  logic                i_sys_clk,
  input  wire  logic                i_rst,
  // axi4-lite write address and data
  input  wire  logic [ADDR_W-1:0]   i_awaddr,
  input  wire  logic                i_awvalid,
  output logic                      o_awready,
  input  wire  logic [31:0]         i_wdata,
  input  wire  logic [3:0]          i_wstrb,
  input  wire  logic                i_wvalid,
  output logic                      o_wready,
  // axi4-lite write response
  output logic [1:0]                o_bresp,
  output logic                      o_bvalid,
  input  wire  logic                i_bready,
  // axi4-lite read
  input  wire  logic [ADDR_W-1:0]   i_araddr,
  input  wire  logic                i_arvalid,
  output logic                      o_arready,
  output logic [31:0]               o_rdata,
  output logic [1:0]                o_rresp,
  output logic                      o_rvalid,
  input  wire  logic                i_rready,
  // analog front end
  input  wire  logic                i_sysref,
  input  wire  logic [NUM_POS-1:0]  i_tap_samples,
  input  wire  logic                i_clk_fall_early,
  // delay and window controls
  output logic                      o_position_step_fine,
  output logic [SEL_W-1:0]          o_sample_position_select,
  output logic                      o_clock_invert_delay,
  output logic [DLY_W-1:0]          o_coarse_delay_step,
  output logic [DLY_W-1:0]          o_fine_delay_step
);

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : merge

  function automatic logic [ADDR_W-1:0] baddr(input logic [11:0] idx);
    return ADDR_W'({idx, 2'b00});
  endfunction : baddr

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [2:0]         sr_sync_reg;
  logic [NUM_POS-1:0] tap_s1_reg;
  logic [NUM_POS-1:0] tap_s2_reg;
  logic [1:0]         early_sync_reg;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      sr_sync_reg    <= 3'h0;
      tap_s1_reg     <= 24'h00_0000;
      tap_s2_reg     <= 24'h00_0000;
      early_sync_reg <= 2'h0;
    end else begin
      sr_sync_reg    <= {sr_sync_reg[1:0], i_sysref};
      tap_s1_reg     <= i_tap_samples;
      tap_s2_reg     <= tap_s1_reg;
      early_sync_reg <= {early_sync_reg[0], i_clk_fall_early};
    end
  end

  wire sysref_rise = sr_sync_reg[1] & ~sr_sync_reg[2];
  wire early_now   = early_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  logic [ADDR_W-1:0] aw_addr_reg;
  logic              aw_full_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              w_full_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [1:0]        rresp_reg;
  logic [31:0]       rdata_reg;
  logic [31:0]       clk_ctrl0_reg;
  logic [31:0]       cal_cfg_reg;
  logic [31:0]       tad_reg;
  logic              cal_en_reg;

  assign o_awready = ~aw_full_reg & ~bvalid_reg;
  assign o_wready  = ~w_full_reg & ~bvalid_reg;
  assign o_arready = ~rvalid_reg;
  assign o_bvalid  = bvalid_reg;
  assign o_bresp   = bresp_reg;
  assign o_rvalid  = rvalid_reg;
  assign o_rresp  = rresp_reg;
  assign o_rdata   = rdata_reg;

  wire wr_go = aw_full_reg & w_full_reg & ~bvalid_reg;
  wire wr_ctl = wr_go && aw_addr_reg == baddr(CLK_CTRL0_IDX);
  wire wr_en  = wr_go && aw_addr_reg == baddr(CAL_EN_IDX);
  wire wr_cfg = wr_go && aw_addr_reg == baddr(CAL_CFG_IDX);
  wire wr_tad = wr_go && aw_addr_reg == baddr(TAD_IDX);
  wire wr_hit = wr_ctl | wr_en | wr_cfg | wr_tad;

  wire [31:0] ctl_merged = merge(clk_ctrl0_reg, w_data_reg, w_strb_reg);
  wire [31:0] en_merged  = merge({31'h0, cal_en_reg}, w_data_reg, w_strb_reg);
  wire [31:0] cfg_merged = merge(cal_cfg_reg, w_data_reg, w_strb_reg);
  wire [31:0] tad_merged = merge(tad_reg, w_data_reg, w_strb_reg);

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      aw_addr_reg <= '0;
      aw_full_reg <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      w_full_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_addr_reg <= i_awaddr;
        aw_full_reg <= 1'b1;
      end
      if (i_wvalid && o_wready) begin
        w_data_reg <= i_wdata;
        w_strb_reg <= i_wstrb;
        w_full_reg <= 1'b1;
      end
      if (wr_go) begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && i_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // window control, calibration config and calibration enable registers
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      clk_ctrl0_reg <= CLK_CTRL0_RST;
      cal_cfg_reg   <= CAL_CFG_RST;
      cal_en_reg    <= 1'b0;
    end else begin
      if (wr_ctl) begin
        // only the first sixteen positions can be chosen
        clk_ctrl0_reg <= {27'h0, ctl_merged[STEP_BIT], ctl_merged[SEL_LSB +: SEL_W]};
      end
      if (wr_cfg) begin
        cal_cfg_reg <= {24'h0, cfg_merged[7:0]};
      end
      if (wr_en) begin
        cal_en_reg <= en_merged[0];
      end
    end
  end

  assign o_position_step_fine     = clk_ctrl0_reg[STEP_BIT];
  assign o_sample_position_select = clk_ctrl0_reg[SEL_LSB +: SEL_W];

  ////////////////////////////////////////////////////////////////////////////
  // position detector
  logic [NUM_POS-1:0] flag_acc_reg;
  logic [1:0]         edge_cnt_reg;
  logic               step_prev_reg;

  // a tap next to a level change in the sampled sysref has little margin
  wire [NUM_POS-1:0] trans    = tap_s2_reg ^ {tap_s2_reg[NUM_POS-2:0], tap_s2_reg[0]};
  wire [NUM_POS-1:0] near_edg = trans | {1'b0, trans[NUM_POS-1:1]};
  wire               flags_ok = edge_cnt_reg == EDGES_NEEDED;
  wire [NUM_POS-1:0] pos_flags = {1'b1, flag_acc_reg[NUM_POS-2:1], 1'b1};

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      flag_acc_reg  <= 24'h00_0000;
      edge_cnt_reg  <= 2'h0;
      step_prev_reg <= 1'b0;
    end else begin
      step_prev_reg <= o_position_step_fine;
      if (step_prev_reg != o_position_step_fine) begin
        // tap spacing changed, start a fresh observation
        flag_acc_reg <= 24'h00_0000;
        edge_cnt_reg <= 2'h0;
      end else if (sysref_rise) begin
        flag_acc_reg <= flag_acc_reg | near_edg;
        if (!flags_ok) begin
          edge_cnt_reg <= edge_cnt_reg + 2'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alignment search
  srwa_cal_state_type state_reg;
  logic [15:0]        settle_reg;
  logic               inv_reg;
  logic [DLY_W-1:0]   coarse_reg;
  logic               prev_early_reg;
  logic [1:0]         hit_reg;
  logic [DLY_W-1:0]   hit_crs0_reg;
  logic [DLY_W-1:0]   hit_crs1_reg;
  logic               done_reg;
  logic               nolock_reg;
  logic               en_prev_reg;
  logic [16:0]        found_reg;

  wire en_rise   = cal_en_reg & ~en_prev_reg;
  wire aligned   = coarse_reg != 8'h00 && prev_early_reg && !early_now;
  wire last_step = aligned || coarse_reg == COARSE_MAX;
  // smaller coarse wins, the non-inverted side on a tie
  wire pick_inv  = hit_reg[1] && (!hit_reg[0] || hit_crs1_reg < hit_crs0_reg);
  wire [DLY_W-1:0] pick_crs = pick_inv ? hit_crs1_reg : hit_crs0_reg;
  wire searching = state_reg != CAL_IDLE && state_reg != CAL_FINISH;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_reg      <= CAL_IDLE;
      settle_reg     <= 16'h0000;
      inv_reg        <= 1'b0;
      coarse_reg     <= 8'h00;
      prev_early_reg <= 1'b0;
      hit_reg        <= 2'h0;
      hit_crs0_reg   <= 8'h00;
      hit_crs1_reg   <= 8'h00;
      done_reg       <= 1'b0;
      nolock_reg     <= 1'b0;
      en_prev_reg    <= 1'b0;
      found_reg      <= 17'h0_0000;
    end else begin
      en_prev_reg <= cal_en_reg;
      if (en_rise) begin
        done_reg   <= 1'b0;
        nolock_reg <= 1'b0;
        inv_reg    <= 1'b0;
        coarse_reg <= 8'h00;
        hit_reg    <= 2'h0;
        settle_reg <= 16'(SETTLE_CYCLES);
        state_reg  <= CAL_SETTLE;
      end else if (!cal_en_reg) begin
        state_reg <= CAL_IDLE;
      end else begin
        case (state_reg)
          CAL_SETTLE: begin
            if (settle_reg <= 16'h0001) begin
              state_reg <= CAL_WAIT_EDGE;
            end else begin
              settle_reg <= settle_reg - 16'h0001;
            end
          end
          CAL_WAIT_EDGE: begin
            if (sysref_rise) begin
              state_reg <= CAL_CHECK;
            end
          end
          CAL_CHECK: begin
            prev_early_reg <= early_now;
            settle_reg     <= 16'(SETTLE_CYCLES);
            state_reg      <= CAL_SETTLE;
            if (aligned && !inv_reg) begin
              hit_reg[0]   <= 1'b1;
              hit_crs0_reg <= coarse_reg;
            end else if (aligned) begin
              hit_reg[1]   <= 1'b1;
              hit_crs1_reg <= coarse_reg;
            end
            if (!last_step) begin
              coarse_reg <= coarse_reg + 8'h01;
            end else if (!inv_reg) begin
              inv_reg    <= 1'b1;
              coarse_reg <= 8'h00;
            end else begin
              state_reg <= CAL_FINISH;
            end
          end
          CAL_FINISH: begin
            found_reg  <= {pick_inv, pick_crs, cal_cfg_reg[7:0]};
            nolock_reg <= hit_reg == 2'h0;
            done_reg   <= 1'b1;
            state_reg  <= CAL_IDLE;
          end
          default: begin
            state_reg <= CAL_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // delay setting, kept after calibration until rewritten
  wire cal_load = state_reg == CAL_FINISH && cal_en_reg && !en_rise;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      tad_reg <= TAD_RST;
    end else if (cal_load) begin
      tad_reg <= {15'h0, pick_inv, pick_crs, cal_cfg_reg[7:0]};
    end else if (wr_tad) begin
      tad_reg <= {15'h0, tad_merged[16:0]};
    end
  end

  // inverting the clock adds half a period of delay
  assign o_clock_invert_delay = searching ? inv_reg : tad_reg[CLOCK_INVERT_DELAY_BIT];
  assign o_coarse_delay_step  = searching ? coarse_reg : tad_reg[TAD_CRS_LSB +: DLY_W];
  assign o_fine_delay_step    = searching ? cal_cfg_reg[7:0] : tad_reg[TAD_FIN_LSB +: DLY_W];

  ////////////////////////////////////////////////////////////////////////////
  // read path
  // done already reads low in the cycle the enable rise is seen
  wire [31:0] stat_word = {5'h0, nolock_reg, flags_ok, done_reg & ~en_rise, 7'h0, found_reg};
  logic [31:0] rd_word;
  logic        rd_hit;

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    if (i_araddr == baddr(CLK_CTRL0_IDX)) begin
      rd_word = clk_ctrl0_reg;
    end else if (i_araddr == baddr(POS_FLAGS0_IDX)) begin
      rd_word = {24'h0, pos_flags[7:0]};
    end else if (i_araddr == baddr(POS_FLAGS1_IDX)) begin
      rd_word = {24'h0, pos_flags[15:8]};
    end else if (i_araddr == baddr(POS_FLAGS2_IDX)) begin
      rd_word = {24'h0, pos_flags[23:16]};
    end else if (i_araddr == baddr(CAL_EN_IDX)) begin
      rd_word = {31'h0, cal_en_reg};
    end else if (i_araddr == baddr(CAL_CFG_IDX)) begin
      rd_word = cal_cfg_reg;
    end else if (i_araddr == baddr(CAL_STAT_IDX)) begin
      rd_word = stat_word;
    end else if (i_araddr == baddr(TAD_IDX)) begin
      rd_word = tad_reg;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
    end else if (i_arvalid && o_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_reg  <= rd_word;
    end else if (rvalid_reg && i_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule : srwa_sysref_window_autocal
`default_nettype wire

// ---- srwa_sysref_window_autocal_asserts.sv ----
// Purpose: port-level checks for the sysref window and alignment block
// Assumes: bound to srwa_sysref_window_autocal, one clock domain
// Notes:   synchronous active-high reset disables every property
`timescale 1ns/1ps
`default_nettype none
module srwa_sysref_window_autocal_asserts
  import srwa_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC
) (
  // clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  // bus requests
  input  wire logic              i_awvalid,
  input  wire logic              i_wvalid,
  input  wire logic              i_bready,
  input  wire logic              i_arvalid,
  input  wire logic              i_rready,
  // bus answers
  input  wire logic              o_awready,
  input  wire logic              o_wready,
  input  wire logic [1:0]        o_bresp,
  input  wire logic              o_bvalid,
  input  wire logic              o_arready,
  input  wire logic [31:0]       o_rdata,
  input  wire logic [1:0]        o_rresp,
  input  wire logic              o_rvalid,
  // controls
  input  wire logic [DLY_W-1:0]  o_coarse_delay_step,
  input  wire logic [SEL_W-1:0]  o_sample_position_select
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  ////////////////////////////////////////////////////////////////////////////
  a_bvalid_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped or changed before bready");
  a_rvalid_hold: assert property (o_rvalid && !i_rready |=>
    o_rvalid && $stable(o_rdata) && $stable(o_rresp))
    else $error("read response dropped or changed before rready");
  a_write_busy: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write channels ready while response pending");
  a_read_busy: assert property (o_rvalid |-> !o_arready)
    else $error("read address ready while read data pending");
  a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read data not one cycle after address");
  a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready |->
    ##[1:2] o_bvalid)
    else $error("write response late");
  a_error_zero: assert property (o_rvalid && o_rresp == RESP_SLVERR |-> o_rdata == 32'h0)
    else $error("error read returned nonzero data");
  a_resp_legal: assert property (o_bvalid |-> o_bresp == RESP_OKAY || o_bresp == RESP_SLVERR)
    else $error("illegal write response code");
  a_reset_idle: assert property ($past(i_rst) |->
    !o_bvalid && !o_rvalid && o_coarse_delay_step == 8'h00)
    else $error("outputs not idle after reset");
  a_select_by_write: assert property (
    !$past(i_rst) && $changed(o_sample_position_select) |-> o_bvalid)
    else $error("position select changed without a write");
endmodule : srwa_sysref_window_autocal_asserts

bind srwa_sysref_window_autocal srwa_sysref_window_autocal_asserts #(
  .SETTLE_CYCLES(SETTLE_CYCLES)
) chk_u (
  .i_sys_clk, .i_rst, .i_awvalid, .i_wvalid, .i_bready, .i_arvalid, .i_rready,
  .o_awready, .o_wready, .o_bresp, .o_bvalid, .o_arready, .o_rdata, .o_rresp,
  .o_rvalid, .o_coarse_delay_step, .o_sample_position_select
);
`default_nettype wire

// ---- srwa_sysref_src.sv ----
// Purpose: periodic sysref source with tap and phase comparator stand-ins
// Assumes: sysref runs continuously once reset is released
// Notes:   alignment point per clock polarity set by parameters
`timescale 1ns/1ps
`default_nettype none
module srwa_sysref_src #(
  parameter int PERIOD = 10,
  parameter int TGT0   = 6,
  parameter int TGT1   = 3
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_inv,
  input  wire logic [7:0]  i_coarse,
  output logic             o_sysref,
  output logic [23:0]      o_taps,
  output logic             o_fall_early
);
  int cnt;

  // every tap sees the same level, so no tap lies near a transition
  always @(posedge i_clk) begin
    cnt <= (i_rst || cnt == PERIOD - 1) ? 0 : cnt + 1;
    o_sysref <= !i_rst && cnt < PERIOD / 2;
    o_taps <= {24{!i_rst && cnt < PERIOD / 2}};
    o_fall_early <= int'(i_coarse) < (i_inv ? TGT1 : TGT0);
  end
endmodule : srwa_sysref_src
`default_nettype wire

// ---- srwa_sysref_window_autocal_tb.sv ----
// Purpose: self-checking bench for the sysref window and alignment block
// Assumes: AXI4-Lite master tasks, register model kept in an associative array
// Notes:   short settle count keeps the search quick
`timescale 1ns/1ps
`default_nettype none
module srwa_sysref_window_autocal_tb import srwa_pkg::*;;
  localparam int TGT0 = 6;
  localparam int TGT1 = 3;
  logic               i_sys_clk = 1'b0;
  logic               i_rst = 1'b1;
  logic [ADDR_W-1:0]  i_awaddr = '0, i_araddr = '0;
  logic [31:0]        i_wdata = '0;
  logic [3:0]         i_wstrb = 4'hF;
  logic               i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic               i_arvalid = 1'b0, i_rready = 1'b0;
  logic               i_sysref, i_clk_fall_early;
  logic [NUM_POS-1:0] i_tap_samples;
  logic               o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0]         o_bresp, o_rresp;
  logic [31:0]        o_rdata, rd, v, e;
  logic               o_position_step_fine, o_clock_invert_delay;
  logic [SEL_W-1:0]   o_sample_position_select;
  logic [DLY_W-1:0]   o_coarse_delay_step, o_fine_delay_step;
  logic [1:0]         rsp;
  int                 fail_count = 0, total_checks = 0;
  int                 model [int], mask [int];

  srwa_sysref_window_autocal #(.SETTLE_CYCLES(4)) dut_u (
    .i_sys_clk, .i_rst, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
    .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
    .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_sysref, .i_tap_samples,
    .i_clk_fall_early, .o_position_step_fine, .o_sample_position_select,
    .o_clock_invert_delay, .o_coarse_delay_step, .o_fine_delay_step
  );
  srwa_sysref_src #(.PERIOD(10), .TGT0(TGT0), .TGT1(TGT1)) src_u (
    .i_clk(i_sys_clk), .i_rst(i_rst), .i_inv(o_clock_invert_delay),
    .i_coarse(o_coarse_delay_step), .o_sysref(i_sysref), .o_taps(i_tap_samples),
    .o_fall_early(i_clk_fall_early)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask : chk

  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_awaddr <= {idx[9:0], 2'b00};
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'($urandom_range(1));
    if (mask.exists(idx)) model[idx] = d & mask[idx];
    for (int n = 0; n < 50; n++) begin
      @(posedge i_sys_clk);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      if (o_bvalid && i_bready) begin
        rsp = o_bresp;
        i_bready <= 1'b0;
        return;
      end
      if (o_bvalid) i_bready <= 1'b1;
    end
    fail_count++;
    results();
  endtask : wr

  task automatic rd_reg(input logic [11:0] idx);
    @(posedge i_sys_clk);
    i_araddr <= {idx[9:0], 2'b00};
    i_arvalid <= 1'b1;
    i_rready <= 1'($urandom_range(1));
    for (int n = 0; n < 50; n++) begin
      @(posedge i_sys_clk);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      if (o_rvalid && i_rready) begin
        rd = o_rdata;
        rsp = o_rresp;
        i_rready <= 1'b0;
        return;
      end
      if (o_rvalid) i_rready <= 1'b1;
    end
    fail_count++;
    results();
  endtask : rd_reg

  task automatic rdchk(input logic [11:0] idx);
    rd_reg(idx);
    chk("readback", model[idx], rd);
  endtask : rdchk

  task automatic poll(input int b);
    for (int n = 0; n < 300; n++) begin
      rd_reg(CAL_STAT_IDX);
      if (rd[b] === 1'b1) return;
    end
    fail_count++;
    results();
  endtask : poll

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  initial begin
    repeat (100000) @(posedge i_sys_clk);
    fail_count++;
    results();
  end

  initial begin
    void'($urandom(32'h4D00));
    mask[CLK_CTRL0_IDX] = 32'h1F;
    mask[CAL_EN_IDX] = 32'h1;
    mask[CAL_CFG_IDX] = 32'hFF;
    mask[TAD_IDX] = 32'h1_FFFF;
    foreach (mask[k]) model[k] = 0;
    repeat (10) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    foreach (model[k]) rdchk(12'(k));
    // each write toggles the step bit, which restarts the edge count
    for (int i = 1; i <= 4; i++) begin
      v = $urandom;
      v[4] = i[0];
      wr(CLK_CTRL0_IDX, v);
      rdchk(CLK_CTRL0_IDX);
      chk("select", v[3:0], o_sample_position_select);
      chk("step fine", v[4], o_position_step_fine);
      rd_reg(CAL_STAT_IDX);
      chk("flags valid", 0, rd[STAT_VALID]);
    end
    wr(CLK_CTRL0_IDX, 32'h0);
    poll(STAT_VALID);
    rd_reg(POS_FLAGS0_IDX);
    chk("flags low", 32'h01, rd);
    rd_reg(POS_FLAGS1_IDX);
    chk("flags mid", 32'h00, rd);
    wr(POS_FLAGS2_IDX, 32'h0);
    rd_reg(POS_FLAGS2_IDX);
    chk("flags high", 32'h80, rd);
    wr(12'h100, $urandom);
    chk("bresp", RESP_SLVERR, rsp);
    rd_reg(12'h100);
    chk("rresp", RESP_SLVERR, rsp);
    chk("unmapped data", 0, rd);
    v = $urandom;
    v[16] = 1'b1;
    wr(TAD_IDX, v);
    rdchk(TAD_IDX);
    chk("invert", 1, o_clock_invert_delay);
    chk("coarse", v[15:8], o_coarse_delay_step);
    chk("fine", v[7:0], o_fine_delay_step);
    v = $urandom;
    wr(CAL_CFG_IDX, v);
    wr(CAL_EN_IDX, 32'h1);
    rd_reg(CAL_STAT_IDX);
    chk("done early", 0, rd[STAT_DONE]);
    poll(STAT_DONE);
    e = {7'h00, 1'b1, 7'h00, 1'(TGT1 < TGT0), 8'(TGT1 < TGT0 ? TGT1 : TGT0), v[7:0]};
    chk("found setting", e, rd & 32'h0501_FFFF);
    model[TAD_IDX] = e & 32'h1_FFFF;
    rdchk(TAD_IDX);
    wr(CAL_EN_IDX, 32'h0);
    chk("kept invert", e[16], o_clock_invert_delay);
    chk("kept coarse", e[15:8], o_coarse_delay_step);
    chk("kept fine", e[7:0], o_fine_delay_step);
    // a second run must pull done low again before it completes
    wr(CAL_EN_IDX, 32'h1);
    rd_reg(CAL_STAT_IDX);
    chk("done rerun", 0, rd[STAT_DONE]);
    poll(STAT_DONE);
    chk("found rerun", e, rd & 32'h0501_FFFF);
    results();
  end
endmodule : srwa_sysref_window_autocal_tb
`default_nettype wire
